/* verilog/sspc_defs.svh */
// Register offsets, field positions, reset values and divider figures of the serial port
`ifndef SSPC_DEFS_SVH
`define SSPC_DEFS_SVH
`define SSPC_ADDR_BUF      8'h13
`define SSPC_ADDR_CTRL     8'h14
`define SSPC_ADDR_STAT     8'h94
`define SSPC_ADDR_IRQ_STAT 8'h20
`define SSPC_ADDR_IRQ_MASK 8'h21
`define SSPC_CTRL_OVF      6
`define SSPC_CTRL_EN       5
`define SSPC_CTRL_CKP      4
`define SSPC_STAT_BF       0
`define SSPC_EV_DONE       0
`define SSPC_EV_OVF        1
`define SSPC_EV_START      2
`define SSPC_EV_STOP       3
`define SSPC_CTRL_RESET    8'h00
`define SSPC_IRQ_RESET     4'h0
`define SSPC_DIV_FAST      7'h04
`define SSPC_DIV_MID       7'h10
`define SSPC_DIV_SLOW      7'h40
`define SSPC_BITS_LAST     4'h7
`define SSPC_BITS_ACK      4'h8
`endif

/* verilog/sspc_pkg.sv */
// Types shared by the serial port control logic
package sspc_pkg;
  typedef enum logic [3:0] {
    SSPC_M_SPI_DIV4  = 4'h0,
    SSPC_M_SPI_DIV16 = 4'h1,
    SSPC_M_SPI_DIV64 = 4'h2,
    SSPC_M_SPI_TMR   = 4'h3,
    SSPC_M_SPI_SS    = 4'h4,
    SSPC_M_SPI_NOSS  = 4'h5,
    SSPC_M_I2C_7     = 4'h6,
    SSPC_M_I2C_10    = 4'h7,
    SSPC_M_RSV8      = 4'h8,
    SSPC_M_RSV9      = 4'h9,
    SSPC_M_RSVA      = 4'ha,
    SSPC_M_I2C_FWM   = 4'hb,
    SSPC_M_RSVC      = 4'hc,
    SSPC_M_RSVD      = 4'hd,
    SSPC_M_I2C_7SP   = 4'he,
    SSPC_M_I2C_10SP  = 4'hf
  } sspc_mode_t;

  typedef enum logic [1:0] {
    SSPC_ST_IDLE  = 2'b00,
    SSPC_ST_LEAD  = 2'b01,
    SSPC_ST_TRAIL = 2'b11
  } sspc_state_t;

  typedef struct packed {
    logic clk;
    logic dat;
    logic sel_n;
  } sspc_pin_in_t;

  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic dat_o;
    logic dat_oe;
    logic sdo_o;
    logic sdo_oe;
  } sspc_pin_out_t;
endpackage

/* verilog/sspc_top.sv */
// Synchronous serial port: control register, SPI engine, I2C slave receive path
// Operation
// - SPI slave new byte while buffer full sets overflow
// - SPI overflow only raised as slave
// - SPI master never raises overflow
// - I2C byte into full buffer sets overflow
// - SPI enable hands clock and data pins over
// - I2C enable uses pins; disable frees pins
// - Mode and enable set pin directions, not software
// - SPI launch edge chosen by clock polarity
// - I2C slave polarity zero holds clock low
// - Modes 0-2: master, oscillator/4, /16, /64
// - Mode 3: master, timer output halved
// - Mode 4: slave with select pin control
// - Mode 5: slave, select pin ignored
// - Modes 6,7: I2C slave 7/10-bit address
// - Mode 11: firmware controlled I2C master
// - Buffer full set on load, cleared empty
`timescale 1ns/1ps
`include "sspc_defs.svh"
module sspc_top (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // Register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [7:0]                  reg_rdata,
  // Second timer output pulse
  input  wire logic                   timer_tick,
  // Serial pins
  input  wire sspc_pkg::sspc_pin_in_t pin_in,
  output sspc_pkg::sspc_pin_out_t     pin_out,
  output logic                        serial_pins_active,
  // Interrupt
  output logic                        irq
);

////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0]            raw_pins;
  logic [2:0]            sync1_q;
  logic [2:0]            sync2_q;
  logic [2:0]            prev_q;

  assign raw_pins = {pin_in.clk, pin_in.dat, pin_in.sel_n};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi]  <= 1'b0;
        end else begin
          sync1_q[gi] <= raw_pins[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi]  <= sync2_q[gi];
        end
      end
    end
  endgenerate

  wire sck_s  = sync2_q[2];
  wire sck_p  = prev_q[2];
  wire dat_s  = sync2_q[1];
  wire dat_p  = prev_q[1];
  wire sel_s  = sync2_q[0];

////////////////////////////////////////////////////////////////////////////////
  // Registers and mode decode
  logic [7:0]            ctrl_q;
  logic [7:0]            buf_q;
  logic                  bf_q;
  logic [3:0]            irq_stat_q;
  logic [3:0]            irq_mask_q;
  logic [7:0]            rdata_q;
  sspc_pkg::sspc_mode_t  mode;

  assign mode = sspc_pkg::sspc_mode_t'(ctrl_q[3:0]);
  wire en      = ctrl_q[`SSPC_CTRL_EN];
  wire clock_polarity_select     = ctrl_q[`SSPC_CTRL_CKP];
  wire is_mstr = en && (mode == sspc_pkg::SSPC_M_SPI_DIV4 || mode == sspc_pkg::SSPC_M_SPI_DIV16 ||
                        mode == sspc_pkg::SSPC_M_SPI_DIV64 || mode == sspc_pkg::SSPC_M_SPI_TMR);
  wire is_sslv = en && (mode == sspc_pkg::SSPC_M_SPI_SS || mode == sspc_pkg::SSPC_M_SPI_NOSS);
  wire i2c_slv = en && (mode == sspc_pkg::SSPC_M_I2C_7 || mode == sspc_pkg::SSPC_M_I2C_10 ||
                        mode == sspc_pkg::SSPC_M_I2C_7SP || mode == sspc_pkg::SSPC_M_I2C_10SP);
  wire i2c_sp  = en && (mode == sspc_pkg::SSPC_M_I2C_FWM || mode == sspc_pkg::SSPC_M_I2C_7SP ||
                        mode == sspc_pkg::SSPC_M_I2C_10SP);
  wire is_i2c  = i2c_slv || i2c_sp;
  wire ss_ctl  = mode == sspc_pkg::SSPC_M_SPI_SS;
  wire slv_act = is_sslv && !(ss_ctl && sel_s);

  // Reserved codes fall through every decode above
  assign serial_pins_active = is_mstr || is_sslv || is_i2c;

  wire wr_buf  = reg_wr && reg_addr == `SSPC_ADDR_BUF;
  wire wr_ctrl = reg_wr && reg_addr == `SSPC_ADDR_CTRL;
  wire wr_ist  = reg_wr && reg_addr == `SSPC_ADDR_IRQ_STAT;
  wire wr_imsk = reg_wr && reg_addr == `SSPC_ADDR_IRQ_MASK;
  wire rd_buf  = reg_rd && reg_addr == `SSPC_ADDR_BUF;

////////////////////////////////////////////////////////////////////////////////
  // Master clock divider
  logic [5:0]            div_q;
  sspc_pkg::sspc_state_t st_q;
  logic [6:0]            div_sel;

  assign div_sel = (mode == sspc_pkg::SSPC_M_SPI_DIV4)  ? `SSPC_DIV_FAST :
                   (mode == sspc_pkg::SSPC_M_SPI_DIV16) ? `SSPC_DIV_MID  : `SSPC_DIV_SLOW;
  wire [5:0] half_last = div_sel[6:1] - 6'h01;
  wire       div_hit   = div_q == half_last;
  wire       half_tick = (mode == sspc_pkg::SSPC_M_SPI_TMR) ? timer_tick : div_hit;
  wire       m_start   = is_mstr && wr_buf && st_q == sspc_pkg::SSPC_ST_IDLE;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 6'h00;
    end else if (m_start || div_hit || st_q == sspc_pkg::SSPC_ST_IDLE) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Shift engine
  logic [7:0]            sr_q;
  logic [3:0]            cnt_q;
  logic                  sck_q;
  logic                  sdo_q;
  logic                  i2c_busy_q;
  logic                  ack_pend_q;
  logic                  ack_drv_q;

  wire m_lead   = is_mstr && st_q == sspc_pkg::SSPC_ST_LEAD && half_tick;
  wire m_trail  = is_mstr && st_q == sspc_pkg::SSPC_ST_TRAIL && half_tick;
  wire sck_chg  = sck_s ^ sck_p;
  wire s_lead   = slv_act && sck_chg && (sck_s != clock_polarity_select);
  wire s_trail  = slv_act && sck_chg && (sck_s == clock_polarity_select);
  wire scl_rise = sck_chg && sck_s;
  wire scl_fall = sck_chg && !sck_s;
  wire i2c_strt = is_i2c && sck_s && sck_p && dat_p && !dat_s;
  wire i2c_stop = is_i2c && sck_s && sck_p && !dat_p && dat_s;
  wire i2c_bit  = i2c_slv && i2c_busy_q && scl_rise && cnt_q != `SSPC_BITS_ACK;
  wire i2c_ackc = i2c_slv && i2c_busy_q && scl_rise && cnt_q == `SSPC_BITS_ACK;
  wire shift_in = m_trail || s_trail || i2c_bit;
  wire launch   = m_lead || s_lead;
  wire byte_done = shift_in && cnt_q == `SSPC_BITS_LAST;
  wire [7:0] new_byte = {sr_q[6:0], dat_s};
  wire ovf_set  = byte_done && bf_q && !is_mstr;
  wire load_buf = byte_done && !ovf_set;
  wire ss_reset = is_sslv && ss_ctl && sel_s;
  wire idle_eng = !serial_pins_active || ss_reset;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= sspc_pkg::SSPC_ST_IDLE;
      sck_q <= 1'b0;
    end else if (!is_mstr) begin
      st_q <= sspc_pkg::SSPC_ST_IDLE;
      sck_q <= clock_polarity_select;
    end else begin
      unique case (st_q)
        sspc_pkg::SSPC_ST_IDLE: begin
          sck_q <= clock_polarity_select;
          if (m_start) begin
            st_q <= sspc_pkg::SSPC_ST_LEAD;
          end
        end
        sspc_pkg::SSPC_ST_LEAD: begin
          if (half_tick) begin
            sck_q <= ~clock_polarity_select;
            st_q <= sspc_pkg::SSPC_ST_TRAIL;
          end
        end
        sspc_pkg::SSPC_ST_TRAIL: begin
          if (half_tick) begin
            sck_q <= clock_polarity_select;
            st_q <= (cnt_q == `SSPC_BITS_LAST) ? sspc_pkg::SSPC_ST_IDLE : sspc_pkg::SSPC_ST_LEAD;
          end
        end
        default: begin
          st_q <= sspc_pkg::SSPC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sr_q <= 8'h00;
      sdo_q <= 1'b0;
    end else if (wr_buf) begin
      sr_q <= reg_wdata;
      sdo_q <= reg_wdata[7];
    end else begin
      if (shift_in) begin
        sr_q <= new_byte;
      end
      if (launch) begin
        sdo_q <= sr_q[7];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 4'h0;
    end else if (idle_eng || m_start || i2c_strt || i2c_ackc) begin
      cnt_q <= 4'h0;
    end else if (shift_in) begin
      cnt_q <= (byte_done && !i2c_slv) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // I2C frame tracking and acknowledge drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      i2c_busy_q <= 1'b0;
      ack_pend_q <= 1'b0;
      ack_drv_q <= 1'b0;
    end else if (!i2c_slv || i2c_stop) begin
      i2c_busy_q <= 1'b0;
      ack_pend_q <= 1'b0;
      ack_drv_q <= 1'b0;
    end else begin
      if (i2c_strt) begin
        i2c_busy_q <= 1'b1;
      end
      if (byte_done) begin
        ack_pend_q <= load_buf;
      end else if (scl_fall && ack_pend_q) begin
        ack_pend_q <= 1'b0;
        ack_drv_q <= 1'b1;
      end else if (scl_fall) begin
        ack_drv_q <= 1'b0;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Register file
  wire [3:0] events = {i2c_stop && i2c_sp, i2c_strt && i2c_sp, ovf_set, byte_done};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `SSPC_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q[5:0] <= reg_wdata[5:0];
      end
      ctrl_q[7] <= 1'b0;
      ctrl_q[`SSPC_CTRL_OVF] <= ovf_set || (wr_ctrl ? reg_wdata[`SSPC_CTRL_OVF] : ctrl_q[`SSPC_CTRL_OVF]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_q <= 8'h00;
      bf_q <= 1'b0;
    end else begin
      if (load_buf) begin
        buf_q <= new_byte;
      end
      bf_q <= load_buf || (bf_q && !rd_buf);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_q <= `SSPC_IRQ_RESET;
      irq_mask_q <= `SSPC_IRQ_RESET;
    end else begin
      irq_stat_q <= events | (irq_stat_q & ~(wr_ist ? reg_wdata[3:0] : 4'h0));
      if (wr_imsk) begin
        irq_mask_q <= reg_wdata[3:0];
      end
    end
  end

  wire [7:0] rd_mux = (reg_addr == `SSPC_ADDR_BUF)      ? buf_q :
                      (reg_addr == `SSPC_ADDR_CTRL)     ? ctrl_q :
                      (reg_addr == `SSPC_ADDR_STAT)     ? {7'h00, bf_q} :
                      (reg_addr == `SSPC_ADDR_IRQ_STAT) ? {4'h0, irq_stat_q} :
                      (reg_addr == `SSPC_ADDR_IRQ_MASK) ? {4'h0, irq_mask_q} : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = |(irq_stat_q & irq_mask_q);

////////////////////////////////////////////////////////////////////////////////
  // Pin drive
  wire stretch = i2c_slv && !clock_polarity_select;
  assign pin_out.clk_o  = is_mstr ? sck_q : 1'b0;
  assign pin_out.clk_oe = is_mstr || stretch;
  assign pin_out.dat_o  = 1'b0;
  assign pin_out.dat_oe = i2c_slv && ack_drv_q;
  assign pin_out.sdo_o  = sdo_q;
  assign pin_out.sdo_oe = is_mstr || slv_act;

////////////////////////////////////////////////////////////////////////////////
  // Checks
  ovf_master_a: assert property (@(posedge clk) disable iff (!reset_n) is_mstr |-> !ovf_set)
    else $error("overflow raised as master");
  ovf_slave_a: assert property (@(posedge clk) disable iff (!reset_n) ovf_set |-> (is_sslv || i2c_slv))
    else $error("overflow raised outside slave modes");
  ovf_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    (byte_done && bf_q && is_sslv) |=> ctrl_q[`SSPC_CTRL_OVF] && buf_q == $past(buf_q))
    else $error("overflow did not discard new byte");
  buf_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    load_buf |=> bf_q && buf_q == $past(new_byte))
    else $error("buffer not loaded with received byte");
  pins_free_a: assert property (@(posedge clk) disable iff (!reset_n)
    !serial_pins_active |-> !(pin_out.clk_oe || pin_out.dat_oe || pin_out.sdo_oe))
    else $error("pin driven while port disabled");
  clk_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    stretch |-> pin_out.clk_oe && !pin_out.clk_o)
    else $error("clock not held low");
  lead_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
    (m_lead && $stable(clock_polarity_select) && !wr_buf && !wr_ctrl) |=> sck_q != clock_polarity_select ##0 sdo_q == $past(sr_q[7]))
    else $error("leading edge wrong");
  div_four_a: assert property (@(posedge clk) disable iff (!reset_n)
    (m_lead && mode == sspc_pkg::SSPC_M_SPI_DIV4) ##1 is_mstr[*2] |-> half_tick)
    else $error("fast divider half period wrong");
  ss_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    ss_reset |=> cnt_q == 4'h0)
    else $error("select high did not reset slave");
  irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
    ((|(events & irq_mask_q)) && !wr_imsk) |=> irq)
    else $error("interrupt missing");
  master_byte_c: cover property (@(posedge clk) disable iff (!reset_n) m_trail && byte_done);
  slave_ovf_c: cover property (@(posedge clk) disable iff (!reset_n) ovf_set && is_sslv);
  i2c_ack_c: cover property (@(posedge clk) disable iff (!reset_n) ack_drv_q ##1 !ack_drv_q);
endmodule

/* sim/sspc_peer.sv */
// Serial bus peer: SPI partner either way and I2C bus master
`timescale 1ns/1ps
module sspc_peer (
  // Clock and pin levels
  input  wire logic clk,
  input  wire logic clock_polarity_select,
  input  wire logic pin_clk,
  input  wire logic pin_sda,
  input  wire logic sdo,
  // Peer drive
  output logic      peer_clk,
  output logic      peer_dat,
  output logic      peer_sel_n
);
  logic [7:0] echo_q = 8'h00;
  logic [7:0] got_q  = 8'h00;
  logic [2:0] cnt_q  = 3'h0;
  logic       last_q = 1'b0;
  logic       arm_q  = 1'b0;
  logic       busy   = 1'b0;
  initial begin
    peer_clk = 1'b0;
    peer_dat = 1'b1;
    peer_sel_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // Answer a device master: capture on trailing, next bit right after it
  // Device input synchronisers lag two cycles, too late for a lead launch
  always @(posedge clk) begin
    last_q <= pin_clk;
    if (!busy)
      peer_clk <= clock_polarity_select;
    if (arm_q && pin_clk !== last_q && pin_clk === clock_polarity_select) begin
      got_q <= {got_q[6:0], sdo};
      cnt_q <= cnt_q + 3'h1;
      arm_q <= (cnt_q != 3'h7);
      peer_dat <= (cnt_q == 3'h7) ? ~peer_dat : echo_q[3'h6 - cnt_q];
    end
  end
  task automatic arm(input logic [7:0] b);
    echo_q <= b;
    cnt_q <= 3'h0;
    arm_q <= 1'b1;
    peer_dat <= b[7];
  endtask
  ////////////////////////////////////////////////////////////
  // Clock a byte into a device slave, MSB first
  task automatic spi_send(input logic [7:0] b, input logic sel);
    busy = 1'b1;
    peer_sel_n <= !sel;
    for (int i = 7; i >= 0; i--) begin
      repeat (8) @(posedge clk);
      peer_dat <= b[i];
      repeat (8) @(posedge clk);
      peer_clk <= !clock_polarity_select;
      repeat (8) @(posedge clk);
      peer_clk <= clock_polarity_select;
    end
    repeat (8) @(posedge clk);
    peer_sel_n <= 1'b1;
    peer_dat <= ~b[0];
    repeat (4) @(posedge clk);
    busy = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  // I2C start or stop, then byte with acknowledge clock
  task automatic i2c_cond(input logic start);
    busy = 1'b1;
    repeat (4) @(posedge clk);
    peer_dat <= start;
    repeat (8) @(posedge clk);
    peer_clk <= 1'b1;
    repeat (8) @(posedge clk);
    peer_dat <= !start;
    repeat (8) @(posedge clk);
    peer_clk <= !start;
    busy = start;
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      peer_dat <= (i == 0) ? 1'b1 : b[i - 1];
      repeat (8) @(posedge clk);
      peer_clk <= 1'b1;
      repeat (8) @(posedge clk);
      ack = pin_sda;
      peer_clk <= 1'b0;
    end
  endtask
endmodule

/* sim/sspc_top_tb.sv */
// Self-checking bench for the serial port control block
`timescale 1ns/1ps
`include "sspc_defs.svh"
module sspc_top_tb;
  localparam logic [7:0] A_BUF = `SSPC_ADDR_BUF;
  localparam logic [7:0] A_CTL = `SSPC_ADDR_CTRL;
  localparam logic [7:0] A_STA = `SSPC_ADDR_STAT;
  localparam logic [7:0] A_IST = `SSPC_ADDR_IRQ_STAT;
  localparam logic [7:0] A_IMK = `SSPC_ADDR_IRQ_MASK;
  logic                    clk;
  logic                    reset_n;
  logic [7:0]              reg_addr;
  logic [7:0]              reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [7:0]              reg_rdata;
  logic                    timer_tick = 1'b0;
  sspc_pkg::sspc_pin_in_t  pin_in;
  sspc_pkg::sspc_pin_out_t pin_out;
  logic                    serial_pins_active;
  logic                    irq;
  logic                    peer_clk;
  logic                    peer_dat;
  logic                    peer_sel_n;
  logic                    clock_polarity_select;
  logic                    ack;
  logic                    rd_pend = 1'b0;
  logic [7:0]              b;
  logic [7:0]              v;
  logic [7:0]              exp_q[$];
  int                      num_errors;
  int                      samples_checked;
  int                      tick_div;
  int                      tick_cnt = 0;
  int                      cnt;
  // Wire levels from every party, pull-up on SDA
  assign pin_in = {pin_out.clk_oe ? pin_out.clk_o : peer_clk, peer_dat & ~pin_out.dat_oe, peer_sel_n};
  sspc_top uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_tick(timer_tick),
    .pin_in(pin_in), .pin_out(pin_out), .serial_pins_active(serial_pins_active), .irq(irq));
  sspc_peer peer (.clk(clk), .clock_polarity_select(clock_polarity_select), .pin_clk(pin_in.clk), .pin_sda(pin_in.dat),
    .sdo(pin_out.sdo_o), .peer_clk(peer_clk), .peer_dat(peer_dat), .peer_sel_n(peer_sel_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt + 1) % tick_div;
    timer_tick <= (tick_cnt == 0);
  end
  ////////////////////////////////////////////////////////////
  // Read results checked against the oldest note
  always @(posedge clk) rd_pend <= reg_rd;
  always @(negedge clk) if (rd_pend) check(reg_rdata, exp_q.pop_front());
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic cfg(input logic [3:0] m, input logic c);
    wr(A_CTL, 8'h00);
    clock_polarity_select <= c;
    repeat (4) @(posedge clk);
    wr(A_CTL, {3'b001, c, m});
    repeat (3) @(negedge clk);
  endtask
  task automatic irq_is(input logic [7:0] e);
    repeat (2) @(negedge clk);
    check(8'(irq), e);
  endtask
  task automatic wait_irq();
    cnt = 0;
    while (irq !== 1'b1 && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
    check(8'(cnt < 2000), 8'h01);
  endtask
  task automatic follow(input logic lvl);
    while (pin_out.clk_o !== lvl && cnt < 400) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Master transfers: sck period, echo byte, no overflow
  task automatic spi_master(input logic [3:0] m, input logic [7:0] per);
    cfg(m, 1'($urandom));
    for (int j = 0; j < 2; j++) begin
      wr(A_IST, 8'h0f);
      b = 8'($urandom);
      v = 8'($urandom);
      peer.arm(v);
      wr(A_BUF, b);
      cnt = 0;
      follow(!clock_polarity_select);
      cnt = 0;
      follow(clock_polarity_select);
      follow(!clock_polarity_select);
      check(8'(cnt), per);
      wait_irq();
    end
    rd(A_CTL, {3'b001, clock_polarity_select, m});
    rd(A_BUF, v);
    check(peer.got_q, b);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    v = $urandom(32'h25fee6e0);
    tick_div = 3 + $urandom % 4;
    {reg_wr, reg_rd, clock_polarity_select, reset_n} = '0;
    {reg_addr, reg_wdata, num_errors, samples_checked} = '0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(negedge clk);
    check(8'(serial_pins_active), 8'h00);
    rd(A_CTL, 8'h00);
    rd(A_STA, 8'h00);
    rd(8'h55, 8'h00);
    wr(A_IMK, 8'h0f);
    rd(A_IMK, 8'h0f);
    for (int m = 0; m < 16; m++) begin
      cfg(4'(m), 1'($urandom));
      check(8'(serial_pins_active), 8'(!(m inside {8, 9, 10, 12, 13})));
      check(8'(pin_out.clk_oe), 8'(m < 4 || (!clock_polarity_select && m inside {6, 7, 14, 15})));
      check(8'(pin_out.sdo_oe), 8'(m < 4 || m == 5));
      check(8'(pin_out.dat_o | pin_out.dat_oe), 8'h00);
      rd(A_CTL, {3'b001, clock_polarity_select, 4'(m)});
    end
    wr(A_CTL, 8'h86);
    repeat (3) @(negedge clk);
    check(8'(serial_pins_active), 8'h00);
    rd(A_CTL, 8'h06);
    spi_master(4'h0, 8'(`SSPC_DIV_FAST));
    spi_master(4'h1, 8'(`SSPC_DIV_MID));
    spi_master(4'h2, 8'(`SSPC_DIV_SLOW));
    spi_master(4'h3, 8'(2 * tick_div));
    cfg(4'h4, 1'b1);
    wr(A_IST, 8'h0f);
    peer.spi_send(8'ha5, 1'b0);
    rd(A_STA, 8'h00);
    b = 8'($urandom);
    v = 8'($urandom);
    peer.spi_send(b, 1'b1);
    peer.spi_send(v, 1'b1);
    rd(A_CTL, 8'h74);
    rd(A_IST, 8'h03);
    rd(A_BUF, b);
    wr(A_CTL, 8'h34);
    rd(A_CTL, 8'h34);
    cfg(4'h5, 1'b0);
    wr(A_IST, 8'h0f);
    b = 8'($urandom);
    peer.spi_send(b, 1'b0);
    wait_irq();
    rd(A_STA, 8'h01);
    rd(A_BUF, b);
    rd(A_STA, 8'h00);
    cfg(4'h6, 1'b1);
    wr(A_IST, 8'h0f);
    peer.i2c_cond(1'b1);
    peer.i2c_byte(b, ack);
    peer.i2c_cond(1'b0);
    check(8'(ack), 8'h00);
    rd(A_IST, 8'h01);
    rd(A_BUF, b);
    cfg(4'he, 1'b1);
    wr(A_IST, 8'h0f);
    peer.i2c_cond(1'b1);
    peer.i2c_byte(b, ack);
    peer.i2c_byte(v, ack);
    peer.i2c_cond(1'b0);
    check(8'(ack), 8'h01);
    rd(A_CTL, 8'h7e);
    rd(A_IST, 8'h0f);
    rd(A_BUF, b);
    cfg(4'hb, 1'b1);
    wr(A_IST, 8'h0f);
    peer.i2c_cond(1'b1);
    peer.i2c_cond(1'b0);
    rd(A_IST, 8'h0c);
    irq_is(8'h01);
    wr(A_IMK, 8'h00);
    irq_is(8'h00);
    wr(A_IMK, 8'h04);
    irq_is(8'h01);
    wr(A_IST, 8'h0c);
    irq_is(8'h00);
    rd(A_IST, 8'h00);
    repeat (3) @(posedge clk);
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
